// File: verilog/pps_pkg.sv
// Package for the power-state controller: encodings, carriers and reset values.
package pps_pkg;

  typedef enum logic [1:0] {
    PPS_D0    = 2'b00,
    PPS_D1    = 2'b01,
    PPS_D2    = 2'b10,
    PPS_D3HOT = 2'b11
  } pps_state_type;

  localparam pps_state_type PPS_STATE_RST = PPS_D0;
  localparam int            PPS_NPORT     = 4;
  localparam int            PPS_AUXW      = 3;
  localparam logic [2:0]    PPS_AUX_ZERO  = 3'h0;
  localparam logic [7:0]    PPS_DATA_ZERO = 8'h00;
  localparam int            PPS_FRST_CYC  = 4;
  localparam logic [2:0]    PPS_FRST_LOAD = 3'(PPS_FRST_CYC);
  localparam int            PPS_STATEBIT  = 0;
  localparam int            PPS_WAKEBIT   = 15;

  // Wake sources on one port.
  typedef struct packed {
    logic resume;
    logic conn_chg;
    logic overcur;
  } pps_wake_type;

  // Host write to the power control/status register.
  typedef struct packed {
    logic          wr;
    pps_state_type state;
    logic          wake_en;
    logic          wake_sts_clr;
  } pps_ctl_type;

endpackage : pps_pkg

// File: verilog/pps_ctrl.sv
// Power-state controller: device states, wake signalling and function reset.
// Operation
// - Full-power state D0 runs all logic normally and is always supported.
// - Optional D1 disables mastering, suspends ports, keeps low-latency saving mode.
// - D2 and D3hot disable bus mastering and keep all ports suspended.
// - D3cold is supported; downstream ports are suspended or disconnected.
// - Wake signal can be raised from every supported state.
// - D3cold wake-support bit set by strap or firmware, read-only to software.
// - Auxiliary current reports only the controller's own maximum draw.
// - Without D3cold wake, auxiliary current and D3 power data read zero.
// - Core power plus hardware or software reset brings the device to D0.
// - Software reset leaves power-management registers unchanged.
// - Hardware reset is the bus reset, optionally a power-on reset.
// - Host writes to the control register move among D0, D1, D2, D3hot.
// - D3cold behaves like D3hot; no logic tells the two apart.
// - Each host-written D3hot to D0 transition asserts an internal function reset.
// - Wake status, wake enable and D3cold wake bit survive that reset.
// - Firmware setup, enumeration and wake context survive that reset.
// - Auxiliary-well registers are not cleared by the D3hot to D0 reset.
// - Auxiliary-well registers reset only on aux power-up or software reset.
// - Controller reset command clears memory-space auxiliary-well bits too.
// - Low-power states may gate USB clocks and suspend transceivers.
// - A wake event sets wake status and drives wake signal when enabled.
// - D1, D2 and D3hot mask functional interrupts.
// - Wake events are resume, connect change and overcurrent, each enabled.
`timescale 1ns/1ps
module pps_ctrl #(
  parameter int          NPORT    = pps_pkg::PPS_NPORT,
  parameter bit          HAS_D1   = 1'b1,
  parameter bit          HAS_D2   = 1'b1,
  parameter logic [2:0]  AUX_CUR  = 3'h1,
  parameter logic [7:0]  D3_DATA  = 8'h10
) (
  // Clock, clock enable and resets.
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_ce,
  input  wire logic                      i_rst,
  input  wire logic                      i_aux_rst,
  input  wire logic                      i_por_n,
  input  wire logic                      i_por_en,
  // Host power-management writes and software reset.
  input  wire pps_pkg::pps_ctl_type      i_ctl,
  input  wire logic                      i_soft_rst,
  input  wire logic                      i_controller_soft_reset_cmd,
  // Straps and firmware.
  input  wire logic                      i_d3c_wake_strap,
  input  wire logic                      i_fw_d3c_wr,
  input  wire logic                      i_fw_d3c_val,
  // Ports: wake sources, enables and suspend state; functional interrupt.
  input  wire pps_pkg::pps_wake_type [NPORT-1:0] i_wake,
  input  wire pps_pkg::pps_wake_type [NPORT-1:0] i_wake_en,
  input  wire logic [NPORT-1:0]          i_port_susp,
  input  wire logic                      i_func_irq,
  // Status and control outputs.
  output pps_pkg::pps_state_type         o_state,
  output logic                           o_wake_sts,
  output logic                           o_wake_en,
  output logic                           o_d3c_wake,
  output logic [2:0]                     o_aux_cur,
  output logic [7:0]                     o_d3_data,
  output logic                           o_bus_master_en,
  output logic                           o_port_susp_req,
  output logic                           o_usb_clk_gate,
  output logic                           o_low_lat,
  output logic                           o_irq,
  output logic                           o_func_rst,
  output logic [NPORT-1:0]               o_wake_src,
  // Open-drain wake pin, active low.
  output logic                           o_pme_n_o,
  output logic                           o_pme_n_oe
);
  import pps_pkg::*;

  pps_state_type    state_r;
  logic             wake_sts_r;
  logic             wake_en_r;
  logic             d3c_wake_r;
  logic             strap_done_r;
  logic [2:0]       frst_cnt_r;
  logic [NPORT-1:0] wake_src_r;
  logic             por_s1_r;
  logic             por_s2_r;
  logic [NPORT-1:0] susp_s1_r;
  logic [NPORT-1:0] susp_s2_r;
  logic [NPORT*3-1:0] wk_s1_r;
  logic [NPORT*3-1:0] wk_s2_r;

  // Power-on, suspend and wake inputs pass two flip-flops; wake enables gate the wake inputs ahead of the first.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      por_s1_r  <= 1'b1;
      por_s2_r  <= 1'b1;
      susp_s1_r <= '0;
      susp_s2_r <= '0;
      wk_s1_r   <= '0;
      wk_s2_r   <= '0;
    end else if (i_ce) begin
      por_s1_r  <= i_por_n;
      por_s2_r  <= por_s1_r;
      susp_s1_r <= i_port_susp;
      susp_s2_r <= susp_s1_r;
      wk_s1_r   <= i_wake & i_wake_en;
      wk_s2_r   <= wk_s1_r;
    end
  end

  // Per-port wake event: any enabled source. Gating is sampled with the event.
  logic [NPORT-1:0] port_wake;
  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      assign port_wake[gp] = |wk_s2_r[gp*3 +: 3];
    end
  endgenerate
  wire any_wake = |port_wake;

  // A power-on pulse acts as hardware reset only when that option is enabled.
  wire hw_rst   = i_por_en & ~por_s2_r;
  // Reset to D0 from hardware or software reset; PM context is not touched.
  wire go_d0    = hw_rst | i_soft_rst;

  // Only supported codes are accepted; others leave the state alone.
  wire req_ok   = (i_ctl.state == PPS_D0) | (i_ctl.state == PPS_D3HOT) |
                  ((i_ctl.state == PPS_D1) & HAS_D1) |
                  ((i_ctl.state == PPS_D2) & HAS_D2);
  wire take_req = i_ctl.wr & req_ok;
  wire d3_to_d0 = take_req & (state_r == PPS_D3HOT) & (i_ctl.state == PPS_D0);

  pps_state_type state_nxt;
  assign state_nxt = go_d0 ? PPS_D0 : (take_req ? i_ctl.state : state_r);

  // State and function-reset pulse. D3cold is the D3hot code with core power gone.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r    <= PPS_STATE_RST;
      frst_cnt_r <= 3'h0;
    end else if (i_ce) begin
      state_r    <= state_nxt;
      if (d3_to_d0)
        frst_cnt_r <= PPS_FRST_LOAD;
      else if (frst_cnt_r != 3'h0)
        frst_cnt_r <= frst_cnt_r - 3'h1;
    end
  end

  // PM registers live in the auxiliary well: only aux power-up clears them,
  // so neither software reset nor the function reset disturbs them.
  always_ff @(posedge i_sys_clk or posedge i_aux_rst) begin
    if (i_aux_rst) begin
      wake_sts_r   <= 1'b0;
      wake_en_r    <= 1'b0;
      d3c_wake_r   <= 1'b0;
      strap_done_r <= 1'b0;
    end else if (i_ce) begin
      // Set wins over a clear in the same cycle.
      if (any_wake)
        wake_sts_r <= 1'b1;
      else if (i_ctl.wr & i_ctl.wake_sts_clr)
        wake_sts_r <= 1'b0;
      if (i_ctl.wr)
        wake_en_r <= i_ctl.wake_en;
      // Strap caught once after release, firmware may override afterward.
      if (!strap_done_r) begin
        d3c_wake_r   <= i_d3c_wake_strap;
        strap_done_r <= 1'b1;
      end else if (i_fw_d3c_wr)
        d3c_wake_r <= i_fw_d3c_val;
    end
  end

  // Wake source bits in the aux well; cleared by software or controller reset.
  always_ff @(posedge i_sys_clk or posedge i_aux_rst) begin
    if (i_aux_rst)
      wake_src_r <= '0;
    else if (i_ce) begin
      for (int i = 0; i < NPORT; i++) begin
        if (port_wake[i])
          wake_src_r[i] <= 1'b1;
        else if (i_soft_rst | i_controller_soft_reset_cmd)
          wake_src_r[i] <= 1'b0;
      end
    end
  end

  wire in_d0 = (state_r == PPS_D0);

  assign o_state         = state_r;
  assign o_wake_sts      = wake_sts_r;
  assign o_wake_en       = wake_en_r;
  assign o_d3c_wake      = d3c_wake_r;
  // Own draw only; zero when D3cold wake is off.
  assign o_aux_cur       = d3c_wake_r ? AUX_CUR : PPS_AUX_ZERO;
  assign o_d3_data       = d3c_wake_r ? D3_DATA : PPS_DATA_ZERO;
  assign o_bus_master_en = in_d0;
  assign o_port_susp_req = ~in_d0;
  assign o_usb_clk_gate  = ~in_d0 & (&susp_s2_r);
  assign o_low_lat       = (state_r == PPS_D1);
  assign o_irq           = in_d0 & i_func_irq;
  assign o_func_rst      = (frst_cnt_r != 3'h0);
  assign o_wake_src      = wake_src_r;
  // Wake pin works in every state, D3cold included via the aux well.
  assign o_pme_n_o       = 1'b0;
  assign o_pme_n_oe      = wake_sts_r & wake_en_r;

  // Assertions.
  property p_wake_set;
    @(posedge i_sys_clk) disable iff (i_rst || i_aux_rst)
      (i_ce && any_wake) |=> wake_sts_r;
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake status not set");

  property p_pme;
    @(posedge i_sys_clk) disable iff (i_rst || i_aux_rst)
      o_pme_n_oe == (wake_sts_r && wake_en_r);
  endproperty
  a_pme: assert property (p_pme) else $error("wake pin mismatch");

  property p_frst;
    @(posedge i_sys_clk) disable iff (i_rst || i_aux_rst)
      (i_ce && d3_to_d0 && !go_d0) |=> o_func_rst && state_r == PPS_D0 && wake_en_r == $past(i_ctl.wake_en);
  endproperty
  a_frst: assert property (p_frst) else $error("no function reset on D3hot exit");

  property p_aux_zero;
    @(posedge i_sys_clk) disable iff (i_rst || i_aux_rst)
      !d3c_wake_r |-> (o_aux_cur == 3'h0 && o_d3_data == 8'h00);
  endproperty
  a_aux_zero: assert property (p_aux_zero) else $error("aux current not zero");

  property p_mask;
    @(posedge i_sys_clk) disable iff (i_rst || i_aux_rst)
      (state_r != PPS_D0) |-> (!o_irq && !o_bus_master_en && o_port_susp_req);
  endproperty
  a_mask: assert property (p_mask) else $error("low-power state not quiet");

  property p_soft;
    @(posedge i_sys_clk) disable iff (i_rst || i_aux_rst)
      (i_ce && i_soft_rst && !any_wake && !i_ctl.wr && !i_fw_d3c_wr && strap_done_r)
        |=> $stable(wake_sts_r) && $stable(wake_en_r) && $stable(d3c_wake_r) && state_r == PPS_D0;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset disturbed PM registers");

  property p_req;
    @(posedge i_sys_clk) disable iff (i_rst || i_aux_rst)
      (i_ce && i_ctl.wr && !req_ok && !go_d0) |=> $stable(state_r);
  endproperty
  a_req: assert property (p_req) else $error("unsupported state taken");

  property p_move;
    @(posedge i_sys_clk) disable iff (i_rst || i_aux_rst)
      (i_ce && take_req && !go_d0) |=> state_r == $past(i_ctl.state);
  endproperty
  a_move: assert property (p_move) else $error("state write not applied");

  property p_hold;
    @(posedge i_sys_clk) disable iff (i_rst || i_aux_rst)
      (i_ce && !take_req && !go_d0) |=> $stable(state_r);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved without a write");

  property p_freeze;
    @(posedge i_sys_clk) disable iff (i_rst || i_aux_rst)
      !i_ce |=> $stable(state_r) && $stable(frst_cnt_r) && $stable(wake_sts_r) && $stable(wake_src_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

  property p_hwrst;
    @(posedge i_sys_clk) disable iff (i_rst || i_aux_rst)
      (i_ce && hw_rst) |=> state_r == PPS_D0;
  endproperty
  a_hwrst: assert property (p_hwrst) else $error("power-on reset did not reach D0");

  property p_frst_end;
    @(posedge i_sys_clk) disable iff (i_rst || i_aux_rst)
      (i_ce && frst_cnt_r == 3'h1 && !d3_to_d0) |=> !o_func_rst;
  endproperty
  a_frst_end: assert property (p_frst_end) else $error("function reset too long");

  property p_frst_cause;
    @(posedge i_sys_clk) disable iff (i_rst || i_aux_rst)
      $rose(o_func_rst) |-> $past(d3_to_d0);
  endproperty
  a_frst_cause: assert property (p_frst_cause) else $error("function reset without D3hot exit");

  property p_en_keep;
    @(posedge i_sys_clk) disable iff (i_rst || i_aux_rst)
      (i_ce && !i_ctl.wr) |=> $stable(wake_en_r);
  endproperty
  a_en_keep: assert property (p_en_keep) else $error("wake enable changed without a write");

  property p_src;
    @(posedge i_sys_clk) disable iff (i_rst || i_aux_rst)
      (i_ce && any_wake) |=> (wake_src_r & $past(port_wake)) == $past(port_wake);
  endproperty
  a_src: assert property (p_src) else $error("wake source not recorded");

  property p_gate;
    @(posedge i_sys_clk) disable iff (i_rst || i_aux_rst)
      o_usb_clk_gate |-> (!o_bus_master_en && o_port_susp_req);
  endproperty
  a_gate: assert property (p_gate) else $error("clock gated while in D0");

endmodule : pps_ctrl

// File: verification/pps_host_model.sv
// Host-side model: power-management software issuing control register writes.
`timescale 1ns/1ps
module pps_host_model
  import pps_pkg::*;
(
  // Clock.
  input  wire logic                 i_sys_clk,
  // Request from the bench.
  input  wire logic                 i_go,
  input  wire pps_state_type        i_state,
  input  wire logic                 i_wen,
  input  wire logic                 i_clr,
  // Towards the controller.
  output pps_ctl_type               o_ctl,
  output logic [PPS_NPORT-1:0]      o_port_susp,
  output logic                      o_busy
);
  int                   ph     = 0;
  pps_ctl_type          ctl_r  = '0;
  logic [PPS_NPORT-1:0] susp_r = '0;

  // Ports are suspended a few cycles ahead so the controller sees them settled before the write.
  // The write strobe is rebuilt every cycle, so it is high for exactly one rising edge.
  always @(negedge i_sys_clk) begin
    ctl_r <= '{(ph == 4), i_state, i_wen, i_clr};
    if (ph == 0 && i_go) begin
      if (i_state != PPS_D0) susp_r <= '1;
      ph <= 1;
    end else if (ph > 0 && ph < 4) begin
      ph <= ph + 1;
    end else if (ph == 4) begin
      if (i_state == PPS_D0) susp_r <= '0;
      ph <= 0;
    end
  end

  assign o_ctl       = ctl_r;
  assign o_port_susp = susp_r;
  assign o_busy      = (ph != 0);
endmodule : pps_host_model

// File: verification/pps_ctrl_bench.sv
// Self-checking bench for the power-state controller.
`timescale 1ns/1ps
module pps_ctrl_bench;
  import pps_pkg::*;
  localparam logic [2:0] AUXC = 3'h5;
  localparam logic [7:0] D3D  = 8'h3C;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_aux_rst = 1'b1, i_soft_rst = 1'b0, i_cmd = 1'b0;
  logic i_fw_wr = 1'b0, i_fw_val = 1'b0, i_func_irq = 1'b1;
  logic i_ce = 1'b1, i_por_n = 1'b1, i_por_en = 1'b0;
  pps_wake_type [PPS_NPORT-1:0] i_wake = '0;
  pps_wake_type [PPS_NPORT-1:0] i_wake_en = '1;
  pps_ctl_type ctl;
  pps_state_type o_state, go_state = PPS_D0;
  logic [PPS_NPORT-1:0] port_susp, wake_src;
  logic wake_sts, wake_en, d3c, bme, psr, gate, ll, irq, frst, pme_o, pme_oe, busy;
  logic go = 1'b0, go_wen = 1'b0, go_clr = 1'b0;
  logic [2:0] aux_cur;
  logic [7:0] d3_data;
  int failures = 0, n_compared = 0, frst_cnt = 0;
  logic [1:0] row_st [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
  logic [4:0] row_exp [4] = '{5'h0E, 5'h0A, 5'h11, 5'h0A};

  pps_ctrl #(.NPORT(PPS_NPORT), .HAS_D1(1'b1), .HAS_D2(1'b1), .AUX_CUR(AUXC), .D3_DATA(D3D)) i_pps_ctrl (
    .i_sys_clk(i_sys_clk), .i_ce(i_ce), .i_rst(i_rst), .i_aux_rst(i_aux_rst), .i_por_n(i_por_n),
    .i_por_en(i_por_en), .i_ctl(ctl), .i_soft_rst(i_soft_rst), .i_controller_soft_reset_cmd(i_cmd),
    .i_d3c_wake_strap(1'b0), .i_fw_d3c_wr(i_fw_wr), .i_fw_d3c_val(i_fw_val), .i_wake(i_wake),
    .i_wake_en(i_wake_en), .i_port_susp(port_susp), .i_func_irq(i_func_irq), .o_state(o_state),
    .o_wake_sts(wake_sts), .o_wake_en(wake_en), .o_d3c_wake(d3c), .o_aux_cur(aux_cur),
    .o_d3_data(d3_data), .o_bus_master_en(bme), .o_port_susp_req(psr), .o_usb_clk_gate(gate),
    .o_low_lat(ll), .o_irq(irq), .o_func_rst(frst), .o_wake_src(wake_src), .o_pme_n_o(pme_o),
    .o_pme_n_oe(pme_oe));

  pps_host_model i_pps_host_model (.i_sys_clk(i_sys_clk), .i_go(go), .i_state(go_state),
    .i_wen(go_wen), .i_clr(go_clr), .o_ctl(ctl), .o_port_susp(port_susp), .o_busy(busy));

  initial forever #10 i_sys_clk = ~i_sys_clk;
  always @(negedge i_sys_clk) if (frst === 1'b1) frst_cnt <= frst_cnt + 1;

  task automatic end_of_test();
    if (failures == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask : cyc

  // Bounded wait on the host model, so a stuck handshake ends the run.
  task automatic pm_write(input pps_state_type s, input logic w, input logic c);
    int k;
    go_state <= s;
    go_wen   <= w;
    go_clr   <= c;
    go       <= 1'b1;
    cyc(1);
    go <= 1'b0;
    // The model takes the request at this edge; its busy flag is visible one cycle later.
    cyc(1);
    for (k = 0; k < 20 && busy !== 1'b0; k++) cyc(1);
    if (busy !== 1'b0) begin
      failures++;
      end_of_test();
    end
    cyc(2);
  endtask : pm_write

  initial begin
    cyc(3);
    i_rst     <= 1'b0;
    i_aux_rst <= 1'b0;
    cyc(2);
    chk(o_state, PPS_D0);
    chk({wake_sts, d3c, aux_cur, d3_data}, '0);
    for (int r = 0; r < 4; r++) begin
      pm_write(pps_state_type'(row_st[r]), 1'b0, 1'b0);
      chk(o_state, row_st[r]);
      chk({bme, psr, ll, gate, irq}, row_exp[r]);
    end
    // Every wake source kind on port 1 while in D3hot, with the wake pin still disabled.
    for (int j = 0; j < 3; j++) begin
      i_cmd <= 1'b1;
      cyc(1);
      i_cmd <= 1'b0;
      cyc(2);
      chk(wake_src, '0);
      i_wake[1] <= pps_wake_type'(3'h4 >> j);
      cyc(5);
      chk(wake_src, 4'h2);
      chk({wake_sts, pme_oe}, 2'b10);
      i_wake[1] <= '0;
      cyc(4);
    end
    pm_write(PPS_D3HOT, 1'b1, 1'b0);
    chk({pme_oe, pme_o}, 2'b10);
    pm_write(PPS_D0, 1'b1, 1'b0);
    cyc(6);
    chk(frst_cnt, 16'd4);
    chk({wake_sts, wake_en}, 2'b11);
    chk(wake_src, 4'h2);
    i_fw_wr  <= 1'b1;
    i_fw_val <= 1'b1;
    cyc(1);
    i_fw_wr <= 1'b0;
    cyc(2);
    chk({d3c, aux_cur, d3_data}, {1'b1, AUXC, D3D});
    pm_write(PPS_D1, 1'b1, 1'b0);
    i_soft_rst <= 1'b1;
    cyc(1);
    i_soft_rst <= 1'b0;
    cyc(2);
    chk(o_state, PPS_D0);
    chk({wake_sts, wake_en, d3c}, 3'b111);
    chk(wake_src, '0);
    pm_write(PPS_D0, 1'b0, 1'b1);
    chk({wake_sts, pme_oe}, 2'b00);
    i_func_irq <= 1'b0;
    cyc(1);
    chk(irq, 1'b0);
    // A write issued while the clock enable is low must be lost.
    i_ce <= 1'b0;
    pm_write(PPS_D2, 1'b1, 1'b0);
    i_ce <= 1'b1;
    cyc(1);
    chk({o_state, wake_en}, {PPS_D0, 1'b0});
    pm_write(PPS_D2, 1'b1, 1'b0);
    // The power-on pin only acts once its option is switched on.
    i_por_n <= 1'b0;
    cyc(4);
    chk(o_state, PPS_D2);
    i_por_en <= 1'b1;
    cyc(2);
    i_por_n <= 1'b1;
    cyc(4);
    chk({o_state, wake_en, d3c}, {PPS_D0, 2'b11});
    // Bus reset in mid-run: back to D0, aux-well bits untouched, no function reset.
    pm_write(PPS_D3HOT, 1'b1, 1'b0);
    i_rst <= 1'b1;
    cyc(3);
    i_rst <= 1'b0;
    cyc(2);
    chk({o_state, wake_en, d3c, frst}, {PPS_D0, 3'b110});
    end_of_test();
  end
endmodule : pps_ctrl_bench
